// ===== rtl/option_loader_defines.svh
`ifndef OPTION_LOADER_DEFINES_SVH
`define OPTION_LOADER_DEFINES_SVH

// program memory map
`define OPT_ADDR          15'h3FFF
`define OPT_ALIAS_ADDR    16'hFFFF
`define LAST_PAGE_BASE    15'h3FC0
`define FACTORY_OPT       8'h00
`define SECURED_READ      8'hFF
`define RESERVED_MASK     8'hD8

// option byte fields
`define OPT_SECURITY_BIT  5
`define OPT_WDOG_BIT      2
`define OPT_HALT_BIT      1
`define OPT_BOOT_BIT      0

// core and peripheral reset values
`define PC_RESET          15'h0000
`define SP_RESET          8'h6F
`define IDLE_TIMER_CTRL_RESET        8'h40
`define USART_CTRL_RESET  8'h00
`define TX_BUFFER_EMPTY_FLAG_RESET        1'b1
`define PROG_TIMING_REG_10MHZ      8'h7B
`define WD_WINDOW_MAX     2'h3

// clock monitor recovery, in idle-timer clocks
`define CLKMON_RECOVER_MIN 16
`define CLKMON_RECOVER_MAX 32
`define CLK_MHZ            40
`define TIMER0_DIV         8'h27

`endif

// ===== rtl/option_loader_pkg.sv
package option_loader_pkg;

    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10,
        OP_ERASE = 2'b11
    } flash_op_t;

    typedef struct packed {
        flash_op_t   op;
        logic        mass;
        logic        user_isp;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } flash_req_t;

    typedef struct packed {
        logic secure;
        logic wdog_en;
        logic halt_allowed;
        logic boot_flash;
    } options_t;

    typedef struct packed {
        logic [14:0] pc;
        logic [7:0]  sp;
        logic [7:0]  processor_status_reg;
        logic [7:0]  core_control_reg;
        logic [7:0]  interrupt_control_reg;
        logic [7:0]  seg;
    } core_init_t;

    typedef struct packed {
        logic [7:0] t2ctrl;
        logic [7:0] hst_ctrl;
        logic [7:0] idle_ctrl;
        logic [7:0] wk_en;
        logic [7:0] wk_edge;
        logic [7:0] usart_psr;
        logic [7:0] usart_ctrl;
        logic       tx_buffer_empty_flag;
        logic [7:0] conv_ctrl;
        logic [7:0] prog_lo;
        logic [7:0] prog_hi;
        logic [7:0] prog_tim;
        logic [1:0] wd_window;
        logic       clkmon_armed;
    } periph_init_t;

    typedef enum logic [1:0] {
        CM_OK    = 2'b00,
        CM_ERROR = 2'b01,
        CM_WAIT  = 2'b10
    } clkmon_state_t;

endpackage

// ===== rtl/sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta;

    // meta is read only by q
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sync2

// ===== rtl/option_security_reset_init.sv
`timescale 1ns/1ps
`include "option_loader_defines.svh"
module option_security_reset_init (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic                          reset_pin_n,
    input  wire logic                          brownout_req,
    input  wire logic                          prog_mode,
    input  wire logic                          clk_freq_ok,
    input  wire option_loader_pkg::flash_req_t req,
    input  wire logic                          req_valid,
    input  wire logic [7:0]                    array_rdata,
    output option_loader_pkg::options_t        opts,
    output option_loader_pkg::core_init_t      core_init,
    output option_loader_pkg::periph_init_t    periph_init,
    output logic [7:0]                         rdata,
    output logic                               rdata_valid,
    output logic                               refused,
    output logic                               array_we,
    output logic                               array_erase,
    output logic                               array_mass,
    output logic [14:0]                        array_addr,
    output logic [7:0]                         array_wdata,
    output logic [7:0]                         option_config_byte,
    output logic                               dev_reset,
    output logic                               ports_output_en,
    output logic                               port_g_bit0_pullup,
    output logic                               port_g_bit2_pullup,
    output logic                               watchdog_pin_o,
    output logic                               watchdog_pin_oe,
    output logic                               watchdog_pullup,
    output logic                               retain_state
);
    import option_loader_pkg::*;

    logic          pin_n_s;
    logic          bor_s;
    logic          clk_ok_s;
    logic          init_req;
    logic          opt_written;
    logic          cold;
    logic [7:0]    next_opt;
    logic          is_opt;
    logic          secure;
    logic [7:0]    t0_div;
    logic          t0_tick;
    logic [5:0]    cm_count;
    clkmon_state_t cm_state;

    // pins come from outside the clock domain
    sync2 #(.RESET_VAL(1'b0)) u_sync_pin (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (reset_pin_n),
        .q        (pin_n_s)
    );
    sync2 #(.RESET_VAL(1'b1)) u_sync_bor (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (brownout_req),
        .q        (bor_s)
    );
    sync2 #(.RESET_VAL(1'b0)) u_sync_clk (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (clk_freq_ok),
        .q        (clk_ok_s)
    );

    // either source starts initialisation; a pulse also ends halt upstream
    assign init_req = !pin_n_s || bor_s;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dev_reset <= 1'b1;
        end else begin
            dev_reset <= init_req;
        end
    end

    // cold flag: power-on rst marks state random until first release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cold         <= 1'b1;
            retain_state <= 1'b0;
        end else begin
            if (!dev_reset) begin
                cold <= 1'b0;
            end
            retain_state <= !cold;
        end
    end

    assign is_opt = (req.addr[14:0] == `OPT_ADDR) || (req.addr == `OPT_ALIAS_ADDR);
    assign secure = option_config_byte[`OPT_SECURITY_BIT];

    // reserved bits are forced to zero on any write
    always_comb begin
        next_opt = req.wdata & ~`RESERVED_MASK;
    end

    // nonvolatile option byte image; only a one-shot write after erase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            option_config_byte <= `FACTORY_OPT;
            opt_written        <= 1'b0;
        end else if (req_valid && !dev_reset) begin
            if (req.op == OP_ERASE && req.mass) begin
                option_config_byte <= `FACTORY_OPT;
                opt_written        <= 1'b0;
            end else if (req.op == OP_ERASE && req.addr[14:0] >= `LAST_PAGE_BASE
                         && (!secure || req.user_isp)) begin
                option_config_byte <= `FACTORY_OPT;
                opt_written        <= 1'b0;
            end else if (req.op == OP_WRITE && is_opt && prog_mode && !opt_written
                         && (!secure || req.user_isp)) begin
                option_config_byte <= next_opt;
                opt_written        <= 1'b1;
            end
        end
    end

    // decoded options captured while reset holds, stable before first fetch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opts <= '0;
        end else if (dev_reset) begin
            opts.secure       <= option_config_byte[`OPT_SECURITY_BIT];
            opts.wdog_en      <= !option_config_byte[`OPT_WDOG_BIT];
            opts.halt_allowed <= !option_config_byte[`OPT_HALT_BIT];
            opts.boot_flash   <= option_config_byte[`OPT_BOOT_BIT];
        end
    end

    // access gate towards the flash array
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata       <= 8'h00;
            rdata_valid <= 1'b0;
            refused     <= 1'b0;
            array_we    <= 1'b0;
            array_erase <= 1'b0;
            array_mass  <= 1'b0;
            array_addr  <= 15'h0000;
            array_wdata <= 8'h00;
        end else begin
            rdata_valid <= 1'b0;
            refused     <= 1'b0;
            array_we    <= 1'b0;
            array_erase <= 1'b0;
            array_mass  <= 1'b0;
            if (req_valid && !dev_reset) begin
                array_addr  <= req.addr[14:0];
                array_wdata <= req.wdata;
                case (req.op)
                    OP_READ: begin
                        rdata_valid <= 1'b1;
                        if (is_opt) begin
                            rdata <= option_config_byte;
                        end else if (secure && !req.user_isp) begin
                            rdata <= `SECURED_READ;
                        end else begin
                            rdata <= array_rdata;
                        end
                    end
                    OP_WRITE: begin
                        if ((secure && !req.user_isp) || (is_opt && (!prog_mode || opt_written))) begin
                            refused <= 1'b1;
                        end else if (!is_opt) begin
                            array_we <= 1'b1;
                        end
                    end
                    OP_ERASE: begin
                        if (req.mass) begin
                            array_erase <= 1'b1;
                            array_mass  <= 1'b1;
                        end else if (secure && !req.user_isp) begin
                            refused <= 1'b1;
                        end else begin
                            array_erase <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // core register presets while reset holds
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            core_init <= '0;
        end else if (dev_reset) begin
            core_init.pc     <= `PC_RESET;
            core_init.sp     <= `SP_RESET;
            core_init.processor_status_reg    <= 8'h00;
            core_init.core_control_reg  <= 8'h00;
            core_init.interrupt_control_reg <= 8'h00;
            core_init.seg    <= 8'h00;
        end
    end

    // peripheral presets; converter results are left to the converter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            periph_init <= '0;
        end else if (dev_reset) begin
            periph_init.t2ctrl       <= 8'h00;
            periph_init.hst_ctrl     <= 8'h00;
            periph_init.idle_ctrl    <= `IDLE_TIMER_CTRL_RESET;
            periph_init.wk_en        <= 8'h00;
            periph_init.wk_edge      <= 8'h00;
            periph_init.usart_psr    <= 8'h00;
            periph_init.usart_ctrl   <= `USART_CTRL_RESET;
            periph_init.tx_buffer_empty_flag         <= `TX_BUFFER_EMPTY_FLAG_RESET;
            periph_init.conv_ctrl    <= 8'h00;
            periph_init.prog_lo      <= 8'h00;
            periph_init.prog_hi      <= 8'h00;
            periph_init.prog_tim     <= `PROG_TIMING_REG_10MHZ;
            periph_init.wd_window    <= opts.wdog_en ? `WD_WINDOW_MAX : 2'h0;
            periph_init.clkmon_armed <= opts.wdog_en;
        end
    end

    // idle-timer clock enable, one pulse per divider wrap
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t0_div  <= 8'h00;
            t0_tick <= 1'b0;
        end else begin
            t0_tick <= (t0_div == `TIMER0_DIV);
            t0_div  <= (t0_div == `TIMER0_DIV) ? 8'h00 : t0_div + 8'h01;
        end
    end

    // clock monitor: inhibited in reset, error held until recovery count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cm_state <= CM_OK;
            cm_count <= 6'h00;
        end else if (dev_reset || !opts.wdog_en) begin
            cm_state <= CM_OK;
            cm_count <= 6'h00;
        end else begin
            case (cm_state)
                CM_OK: begin
                    if (!clk_ok_s) begin
                        cm_state <= CM_ERROR;
                    end
                end
                CM_ERROR: begin
                    if (clk_ok_s) begin
                        cm_state <= CM_WAIT;
                        cm_count <= 6'h00;
                    end
                end
                CM_WAIT: begin
                    if (!clk_ok_s) begin
                        cm_state <= CM_ERROR;
                    end else if (t0_tick) begin
                        cm_count <= cm_count + 6'h01;
                        if (cm_count == 6'(`CLKMON_RECOVER_MIN - 1)) begin
                            cm_state <= CM_OK;
                        end
                    end
                end
                default: begin
                    cm_state <= CM_OK;
                end
            endcase
        end
    end

    // pin control: ports float in reset, watchdog pin kept when enabled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ports_output_en    <= 1'b0;
            port_g_bit0_pullup <= 1'b1;
            port_g_bit2_pullup <= 1'b1;
            watchdog_pin_o     <= 1'b1;
            watchdog_pin_oe    <= 1'b0;
            watchdog_pullup    <= 1'b0;
        end else begin
            // taken from init_req so the pins follow dev_reset on the same edge, not one later
            ports_output_en    <= !init_req;
            port_g_bit0_pullup <= init_req;
            port_g_bit2_pullup <= init_req;
            watchdog_pullup    <= opts.wdog_en;
            // open-drain style: drive only the low error level
            watchdog_pin_oe    <= opts.wdog_en && (cm_state != CM_OK);
            watchdog_pin_o     <= 1'b0;
        end
    end
endmodule // option_security_reset_init

// ===== bench/option_loader_checker.sv
`timescale 1ns/1ps
module option_loader_checker (
    input wire logic                          core_clk,
    input wire logic                          rst,
    input wire logic                          reset_pin_n,
    input wire logic                          prog_mode,
    input wire option_loader_pkg::flash_req_t req,
    input wire logic                          req_valid,
    input wire option_loader_pkg::options_t   opts,
    input wire option_loader_pkg::core_init_t core_init,
    input wire option_loader_pkg::periph_init_t periph_init,
    input wire logic [7:0]                    rdata,
    input wire logic                          refused,
    input wire logic                          array_we,
    input wire logic                          array_erase,
    input wire logic                          array_mass,
    input wire logic [7:0]                    option_config_byte,
    input wire logic                          dev_reset,
    input wire logic                          ports_output_en,
    input wire logic                          port_g_bit0_pullup,
    input wire logic                          port_g_bit2_pullup
);
    import option_loader_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // request qualifiers, requests in reset are dropped by the block
    wire take = req_valid && !dev_reset;
    wire rd   = take && req.op == OP_READ;
    wire lock = option_config_byte[5] && !req.user_isp; // gate follows the live byte, not latched opts
    wire opt  = req.addr == 16'h3FFF || req.addr == 16'hFFFF;
    wire wr   = take && req.op == OP_WRITE;
    wire ers  = take && req.op == OP_ERASE;

    property p_sec_read; rd && lock && !opt |=> rdata == 8'hFF; endproperty
    a_sec_read: assert property (p_sec_read) else $error("secured read not FF");
    property p_alias; rd && req.addr == 16'hFFFF |=> rdata == $past(option_config_byte); endproperty
    a_alias: assert property (p_alias) else $error("alias read wrong");
    property p_wr_block; wr && lock |=> refused && !array_we; endproperty
    a_wr_block: assert property (p_wr_block) else $error("secured write went through");
    property p_pg_block; ers && !req.mass && lock |=> refused && !array_erase; endproperty
    a_pg_block: assert property (p_pg_block) else $error("secured page erase went through");
    property p_mass; ers && req.mass |=> array_erase && array_mass && !refused && option_config_byte == 8'h00; endproperty
    a_mass: assert property (p_mass) else $error("mass erase wrong");
    property p_prog_only; wr && req.addr == 16'h3FFF && !prog_mode |=> $stable(option_config_byte); endproperty
    a_prog_only: assert property (p_prog_only) else $error("option written outside programming");
    property p_reserved; (option_config_byte & 8'hD8) == 8'h00; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved option bit set");
    property p_decode;
        $fell(dev_reset) |-> opts == {option_config_byte[5], !option_config_byte[2],
                                      !option_config_byte[1], option_config_byte[0]};
    endproperty
    a_decode: assert property (p_decode) else $error("options not decoded");
    property p_presets;
        $fell(dev_reset) |-> core_init.pc == 15'h0000 && core_init.sp == 8'h6F && core_init.processor_status_reg == 8'h00
            && periph_init.idle_ctrl == 8'h40 && periph_init.tx_buffer_empty_flag && periph_init.usart_ctrl == 8'h00;
    endproperty
    a_presets: assert property (p_presets) else $error("reset presets wrong");
    property p_ports; dev_reset |-> !ports_output_en && port_g_bit0_pullup && port_g_bit2_pullup; endproperty
    a_ports: assert property (p_ports) else $error("ports not released in reset");
    property p_pin; $fell(reset_pin_n) |-> ##[1:3] dev_reset; endproperty
    a_pin: assert property (p_pin) else $error("pin reset not taken");

    c_sec_read: cover property (rd && lock && !opt);
    c_mass: cover property (ers && req.mass);
    c_secure_boot: cover property ($fell(dev_reset) && opts.secure);
endmodule // option_loader_checker

bind option_security_reset_init option_loader_checker chk_u (
    .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n), .prog_mode(prog_mode),
    .req(req), .req_valid(req_valid), .opts(opts), .core_init(core_init),
    .periph_init(periph_init), .rdata(rdata), .refused(refused), .array_we(array_we),
    .array_erase(array_erase), .array_mass(array_mass), .option_config_byte(option_config_byte),
    .dev_reset(dev_reset), .ports_output_en(ports_output_en),
    .port_g_bit0_pullup(port_g_bit0_pullup), .port_g_bit2_pullup(port_g_bit2_pullup)
);

// ===== bench/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic                          core_clk,
    input  wire option_loader_pkg::flash_req_t req,
    input  wire logic                          array_we,
    input  wire logic                          array_erase,
    input  wire logic                          array_mass,
    input  wire logic [14:0]                   array_addr,
    input  wire logic [7:0]                    array_wdata,
    output logic [7:0]                         array_rdata
);
    import option_loader_pkg::*;
    logic [7:0] mem [0:32767];
    // blank cells read 00, so a fresh array looks erased
    initial for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
    // answer in the request cycle, as the block expects
    assign array_rdata = mem[req.addr[14:0]];
    // program, 64-byte page erase or whole-array erase
    always @(posedge core_clk) begin
        if (array_we) mem[array_addr] <= array_wdata;
        if (array_erase) for (int i = 0; i < 32768; i++)
            if (array_mass || i[14:6] == array_addr[14:6]) mem[i] <= 8'h00;
    end
endmodule // flash_array_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
    import option_loader_pkg::*;
    logic core_clk, rst, reset_pin_n, brownout_req, prog_mode, clk_freq_ok, req_valid;
    logic rdata_valid, refused, array_we, array_erase, array_mass, dev_reset, ports_output_en;
    logic port_g_bit0_pullup, port_g_bit2_pullup, watchdog_pin_o, watchdog_pin_oe;
    logic watchdog_pullup, retain_state;
    logic [7:0] array_rdata, rdata, array_wdata, option_config_byte;
    logic [14:0] array_addr;
    flash_req_t req;
    options_t opts;
    core_init_t core_init;
    periph_init_t periph_init;
    int err_total = 0, total_checks = 0, cycles = 0;

    option_security_reset_init dut_u (
        .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n), .brownout_req(brownout_req),
        .prog_mode(prog_mode), .clk_freq_ok(clk_freq_ok), .req(req), .req_valid(req_valid),
        .array_rdata(array_rdata), .opts(opts), .core_init(core_init), .periph_init(periph_init),
        .rdata(rdata), .rdata_valid(rdata_valid), .refused(refused), .array_we(array_we),
        .array_erase(array_erase), .array_mass(array_mass), .array_addr(array_addr),
        .array_wdata(array_wdata), .option_config_byte(option_config_byte), .dev_reset(dev_reset),
        .ports_output_en(ports_output_en), .port_g_bit0_pullup(port_g_bit0_pullup),
        .port_g_bit2_pullup(port_g_bit2_pullup), .watchdog_pin_o(watchdog_pin_o),
        .watchdog_pin_oe(watchdog_pin_oe), .watchdog_pullup(watchdog_pullup), .retain_state(retain_state)
    );
    flash_array_model flash_u (
        .core_clk(core_clk), .req(req), .array_we(array_we), .array_erase(array_erase),
        .array_mass(array_mass), .array_addr(array_addr), .array_wdata(array_wdata),
        .array_rdata(array_rdata)
    );

    // free-running clock, 25 ns
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one request strobe, outputs judged one cycle later
    task automatic op(input flash_op_t o, input logic m, input logic u, input logic [15:0] a,
                      input logic [7:0] d);
        @(posedge core_clk);
        req <= '{op: o, mass: m, user_isp: u, addr: a, wdata: d};
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        #1;
    endtask

    // pin held low well past one instruction cycle
    task automatic pin_reset(input logic [7:0] b);
        @(posedge core_clk);
        reset_pin_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        chk("dev_reset", 1, dev_reset);
        chk("ports", 3'b011, {ports_output_en, port_g_bit0_pullup, port_g_bit2_pullup});
        @(posedge core_clk);
        reset_pin_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        chk("dev_reset_end", 0, dev_reset);
        chk("retain", 1, retain_state);
        chk("opts", {b[5], ~b[2], ~b[1], b[0]}, opts);
    endtask

    task automatic t_defaults();
        chk("option", 8'h00, option_config_byte);
        chk("opts", 4'b0110, opts);
        chk("pc_sp", {15'h0000, 8'h6F}, {core_init.pc, core_init.sp});
        chk("core", 0, {core_init.processor_status_reg, core_init.core_control_reg, core_init.interrupt_control_reg, core_init.seg});
        chk("idle", 8'h40, periph_init.idle_ctrl);
        chk("timers", 0, {periph_init.t2ctrl, periph_init.hst_ctrl, periph_init.wk_en, periph_init.wk_edge});
        chk("usart", 1, {periph_init.usart_psr, periph_init.usart_ctrl, periph_init.tx_buffer_empty_flag});
        chk("conv", {24'h0, 8'h7B}, {periph_init.conv_ctrl, periph_init.prog_lo, periph_init.prog_hi, periph_init.prog_tim});
        chk("wdog", 3'b111, {periph_init.wd_window, periph_init.clkmon_armed});
        chk("wd_pull", 1, watchdog_pullup);
        $display("test defaults done");
    endtask

    task automatic t_program();
        op(OP_WRITE, 0, 0, 16'h0010, 8'h5A);
        chk("we", {1'b1, 15'h0010, 8'h5A, 1'b0}, {array_we, array_addr, array_wdata, refused});
        op(OP_READ, 0, 0, 16'h0010, 8'h00);
        chk("read", {1'b1, 8'h5A}, {rdata_valid, rdata});
        @(posedge core_clk);
        prog_mode <= 1'b0;
        op(OP_WRITE, 0, 0, 16'h3FFF, 8'hFF);
        chk("opt_noprog", 8'h00, option_config_byte);
        @(posedge core_clk);
        prog_mode <= 1'b1;
        op(OP_WRITE, 0, 0, 16'h3FFF, 8'hFF);
        chk("opt_prog", {8'h27, 1'b0}, {option_config_byte, array_we});
        op(OP_WRITE, 0, 1, 16'h3FFF, 8'h00);
        chk("opt_again", {8'h27, 1'b1}, {option_config_byte, refused});
        pin_reset(8'h27);
        $display("test program done");
    endtask

    task automatic t_secured();
        op(OP_READ, 0, 0, 16'h0010, 8'h00);
        chk("sec_read", 8'hFF, rdata);
        op(OP_READ, 0, 0, 16'hFFFF, 8'h00);
        chk("alias", 8'h27, rdata);
        op(OP_READ, 0, 0, 16'h3FFF, 8'h00);
        chk("opt_read", 8'h27, rdata);
        op(OP_READ, 0, 1, 16'h0010, 8'h00);
        chk("isp_read", 8'h5A, rdata);
        op(OP_WRITE, 0, 0, 16'h0010, 8'h11);
        chk("sec_wr", 2'b10, {refused, array_we});
        op(OP_ERASE, 0, 0, 16'h0000, 8'h00);
        chk("sec_pg", 2'b10, {refused, array_erase});
        op(OP_ERASE, 1, 0, 16'h0000, 8'h00);
        chk("mass", {3'b110, 8'h00}, {array_erase, array_mass, refused, option_config_byte});
        op(OP_READ, 0, 0, 16'h0010, 8'h00);
        chk("erased", 8'h00, rdata);
        pin_reset(8'h00);
        $display("test secured done");
    endtask

    task automatic t_brownout();
        @(posedge core_clk);
        brownout_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk("bor_reset", 1, dev_reset);
        op(OP_READ, 0, 0, 16'h0010, 8'h00);
        chk("ignored", 0, rdata_valid);
        @(posedge core_clk);
        brownout_req <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk("bor_end", 0, dev_reset);
        $display("test brownout done");
    endtask

    task automatic t_clkmon();
        int n;
        @(posedge core_clk);
        clk_freq_ok <= 1'b0;
        pin_reset(8'h00);
        repeat (10) @(posedge core_clk);
        #1;
        chk("cm_err", 2'b10, {watchdog_pin_oe, watchdog_pin_o});
        @(posedge core_clk);
        clk_freq_ok <= 1'b1;
        n = 0;
        while (watchdog_pin_oe !== 1'b0 && n < 3000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        // 16 to 32 ticks of 40 cycles, plus sync slack
        chk("cm_recover", 1, n >= 600 && n <= 1340);
        $display("test clkmon done");
    endtask

    // hang guard, run needs under 5000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        rst = 1'b1;
        reset_pin_n = 1'b1;
        brownout_req = 1'b0;
        prog_mode = 1'b1;
        clk_freq_ok = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        t_defaults();
        t_program();
        t_secured();
        t_brownout();
        t_clkmon();
        stop_test();
    end
endmodule // tb
